/* File: logic/sdram_pd_ctrl.sv */
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module sdram_pd_ctrl (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // memory pins from the controller
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic [3:0]  cmd,
  input  wire logic [15:0] addr,
  input  wire logic [2:0]  ba,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // device status
  output logic             input_buf_en,
  output logic             dll_on,
  output logic             odt_async,
  output logic             pd_active,
  output logic             pd_precharge,
  output logic             sr_rate_auto,
  output logic             sr_range_ext,
  output logic             mr2_illegal
);

  typedef struct packed {
    sdram_pd_pkg::pd_state_t state;
    logic                    cke_q;
    logic [7:0]              banks;
    logic                    auto_selfrefresh_enable;
    logic                    extended_temp_select;
    logic                    fast_exit;
    logic                    chop4_fixed;
    logic [7:0]              odt_cnt;
    logic [7:0]              odt_hold;
    logic [31:0]             prdata;
    logic                    pslverr;
  } ctrl_t;

  localparam ctrl_t RESET_VAL = '{
    state: sdram_pd_pkg::PD_RUN, cke_q: 1'b0, banks: 8'h00, auto_selfrefresh_enable: 1'b0, extended_temp_select: 1'b0,
    fast_exit: 1'b0, chop4_fixed: 1'b0, odt_cnt: 8'h00,
    odt_hold: sdram_pd_pkg::ODT_HOLD_RST, prdata: 32'h0000_0000, pslverr: 1'b0};

  ctrl_t       r_reg;
  ctrl_t       r_next;
  pin_if       pins ();
  logic        is_nop;
  logic        cmd_ok;
  logic        slow_pre;
  logic [7:0]  bank_sel;
  logic [31:0] status;

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  pin_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .ck       (ck),
    .cke      (cke),
    .cmd      (cmd),
    .addr     (addr),
    .ba       (ba),
    .pins     (pins)
  );

  // ****************************************************************
  // command decode helpers
  // ****************************************************************
  assign is_nop   = pins.cmd[sdram_pd_pkg::CMD_CS_N_BIT] | (pins.cmd == sdram_pd_pkg::CMD_NOP);
  assign cmd_ok   = r_reg.cke_q & pins.cke & ~pins.cmd[sdram_pd_pkg::CMD_CS_N_BIT];
  assign bank_sel = 8'h01 << pins.ba;
  assign slow_pre = (r_reg.state == sdram_pd_pkg::PD_PRECHARGE) & ~r_reg.fast_exit;

  // status word
  always_comb begin
    status = 32'h0000_0000;
    status[sdram_pd_pkg::ST_STATE_LSB +: 3] = r_reg.state;
    status[sdram_pd_pkg::ST_BANKS_LSB +: 8] = r_reg.banks;
    status[sdram_pd_pkg::ST_BUF_BIT]        = input_buf_en;
    status[sdram_pd_pkg::ST_DLL_BIT]        = dll_on;
    status[sdram_pd_pkg::ST_ODT_BIT]        = odt_async;
    status[sdram_pd_pkg::ST_AUTO_BIT]       = sr_rate_auto;
    status[sdram_pd_pkg::ST_EXT_BIT]        = sr_range_ext;
    status[sdram_pd_pkg::ST_ILLEGAL_BIT]    = mr2_illegal;
    status[sdram_pd_pkg::ST_CHOP4_BIT]      = r_reg.chop4_fixed;
    status[sdram_pd_pkg::ST_FAST_BIT]       = r_reg.fast_exit;
  end

  // ****************************************************************
  // next state: link commands and apb
  // ****************************************************************
  always_comb begin
    r_next = r_reg;
    if (pins.ck_rise) begin
      r_next.cke_q = pins.cke;
      case (r_reg.state)
        sdram_pd_pkg::PD_RUN: begin
          if (r_reg.odt_cnt != 8'h00) begin
            r_next.odt_cnt = r_reg.odt_cnt - 8'h01;
          end
          if (r_reg.cke_q && !pins.cke && is_nop) begin
            // open banks pick the power-down kind
            if (r_reg.banks != 8'h00) begin
              r_next.state = sdram_pd_pkg::PD_ACTIVE;
            end else begin
              r_next.state = sdram_pd_pkg::PD_PRECHARGE;
            end
          end else if (cmd_ok) begin
            case (pins.cmd)
              sdram_pd_pkg::CMD_ACT: r_next.banks = r_reg.banks | bank_sel;
              sdram_pd_pkg::CMD_PRE: begin
                if (pins.addr[sdram_pd_pkg::PRE_ALL_BIT]) begin
                  r_next.banks = 8'h00;
                end else begin
                  r_next.banks = r_reg.banks & ~bank_sel;
                end
              end
              sdram_pd_pkg::CMD_MRS: begin
                if (pins.ba == sdram_pd_pkg::MR2_BA) begin
                  r_next.auto_selfrefresh_enable = pins.addr[sdram_pd_pkg::MR2_ASR_BIT];
                  r_next.extended_temp_select = pins.addr[sdram_pd_pkg::MR2_SRT_BIT];
                end else if (pins.ba == sdram_pd_pkg::MR0_BA) begin
                  r_next.fast_exit   = pins.addr[sdram_pd_pkg::MR0_FAST_EXIT_BIT];
                  r_next.chop4_fixed = (pins.addr[sdram_pd_pkg::MR0_BL_LSB +: 2]
                                        == sdram_pd_pkg::MR0_CHOP4_FIXED);
                end
              end
              default: r_next.banks = r_reg.banks;
            endcase
          end
        end
        sdram_pd_pkg::PD_ACTIVE, sdram_pd_pkg::PD_PRECHARGE: begin
          // commands are not decoded while the buffers are off
          if (pins.cke && is_nop) begin
            r_next.state = sdram_pd_pkg::PD_RUN;
            if (slow_pre) begin
              r_next.odt_cnt = r_reg.odt_hold;
            end
          end
        end
        default: r_next.state = sdram_pd_pkg::PD_RUN;
      endcase
    end
    // apb setup phase latches the answer for the access phase
    if (psel && !penable) begin
      r_next.pslverr = (paddr != sdram_pd_pkg::STATUS_OFS) && (paddr != sdram_pd_pkg::CFG_OFS);
      if (pwrite) begin
        r_next.prdata = 32'h0000_0000;
      end else if (paddr == sdram_pd_pkg::STATUS_OFS) begin
        r_next.prdata = status;
      end else if (paddr == sdram_pd_pkg::CFG_OFS) begin
        r_next.prdata = {24'h00_0000, r_reg.odt_hold};
      end else begin
        r_next.prdata = 32'h0000_0000;
      end
    end
    // apb write takes effect in the access phase
    if (psel && penable && pwrite && paddr == sdram_pd_pkg::CFG_OFS) begin
      r_next.odt_hold = pwdata[sdram_pd_pkg::CFG_HOLD_LSB +: 8];
    end
  end

  // register the whole state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg <= RESET_VAL;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata       = r_reg.prdata;
  assign pready       = 1'b1;
  assign pslverr      = r_reg.pslverr;
  assign pd_active    = r_reg.state == sdram_pd_pkg::PD_ACTIVE;
  assign pd_precharge = r_reg.state == sdram_pd_pkg::PD_PRECHARGE;
  assign input_buf_en = r_reg.state == sdram_pd_pkg::PD_RUN;
  assign dll_on       = ~slow_pre;
  assign odt_async    = slow_pre | (r_reg.odt_cnt != 8'h00);
  assign sr_rate_auto = r_reg.auto_selfrefresh_enable;
  assign sr_range_ext = r_reg.extended_temp_select & ~r_reg.auto_selfrefresh_enable;
  assign mr2_illegal  = r_reg.auto_selfrefresh_enable & r_reg.extended_temp_select; // flags the illegal pair

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence mr2_write_seq;
    pins.ck_rise && cmd_ok && pins.cmd == sdram_pd_pkg::CMD_MRS
      && pins.ba == sdram_pd_pkg::MR2_BA && r_reg.state == sdram_pd_pkg::PD_RUN;
  endsequence

  sequence pd_entry_seq;
    pins.ck_rise && r_reg.state == sdram_pd_pkg::PD_RUN && r_reg.cke_q && !pins.cke && is_nop;
  endsequence

  sequence pd_exit_seq;
    pins.ck_rise && r_reg.state != sdram_pd_pkg::PD_RUN && pins.cke && is_nop;
  endsequence

  chk_ext_range: assert property (mr2_write_seq |=>
    sr_range_ext == ($past(pins.addr[7]) & ~$past(pins.addr[6])))
    else $error("extended range select wrong after mode write");

  chk_auto_rate: assert property (mr2_write_seq and pins.addr[6] |=> sr_rate_auto)
    else $error("auto self refresh not enabled");

  chk_pd_entry: assert property (pd_entry_seq |=> !input_buf_en)
    else $error("power-down not entered");

  chk_bad_entry: assert property (
    pins.ck_rise && r_reg.state == sdram_pd_pkg::PD_RUN && !pins.cke && !is_nop |=> input_buf_en)
    else $error("power-down entered without nop");

  chk_buffers_off: assert property (pd_active || pd_precharge |-> !input_buf_en)
    else $error("buffers on in power-down");

  chk_odt_hold: assert property ($fell(pd_precharge) && !r_reg.fast_exit && r_reg.odt_hold > 8'h01
    |-> odt_async [*2])
    else $error("termination left asynchronous mode too early");

  chk_pd_kind: assert property (pd_entry_seq |=> (pd_active == ($past(r_reg.banks) != 8'h00))
    && (pd_precharge == ($past(r_reg.banks) == 8'h00)))
    else $error("wrong power-down kind");

  chk_dll_state: assert property (pd_precharge |-> dll_on == r_reg.fast_exit)
    else $error("loop state wrong in precharge power-down");

  chk_pd_exit: assert property (pd_exit_seq |=> input_buf_en ##1 input_buf_en)
    else $error("power-down not exited");

  // ****************************************************************
  // termination hold and register checks
  // ****************************************************************
  // slow-exit precharge power-down left on this link edge
  sequence slow_exit_seq;
    pins.ck_rise && slow_pre && pins.cke && is_nop;
  endsequence

  // a run-state link edge with the hold counter still going
  sequence odt_tick_seq;
    pins.ck_rise && r_reg.state == sdram_pd_pkg::PD_RUN && r_reg.odt_cnt != 8'h00;
  endsequence

  chk_banks_frozen: assert property (
    pd_active || pd_precharge |=> $stable(r_reg.banks))
    else $error("bank map changed in power-down");

  chk_auto_wins: assert property (sr_rate_auto |-> !sr_range_ext)
    else $error("range select shown while auto self refresh on");

  chk_slow_odt: assert property (pd_precharge && !r_reg.fast_exit |-> odt_async)
    else $error("termination not asynchronous in slow-exit power-down");

  chk_odt_load: assert property (
    slow_exit_seq |=> r_reg.odt_cnt == $past(r_reg.odt_hold))
    else $error("termination hold not loaded at exit");

  chk_odt_count: assert property (
    odt_tick_seq |=> r_reg.odt_cnt == $past(r_reg.odt_cnt) - 8'h01)
    else $error("termination hold did not count down");

  // register writes and refused addresses
  chk_cfg_write: assert property (psel && penable && pwrite && paddr == sdram_pd_pkg::CFG_OFS
    |=> r_reg.odt_hold == $past(pwdata[7:0])) // cfg hold lands
    else $error("hold value not stored");

  chk_unmapped_err: assert property (psel && !penable && paddr != sdram_pd_pkg::STATUS_OFS
    && paddr != sdram_pd_pkg::CFG_OFS |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped address not refused");

endmodule : sdram_pd_ctrl

/* File: logic/sdram_pd_pkg.sv */
package sdram_pd_pkg;

  // ****************************************************************
  // command codes {cs_n, ras_n, cas_n, we_n}
  // ****************************************************************
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam int         CMD_CS_N_BIT = 3;

  // ****************************************************************
  // mode register fields, precharge-all bit and bank count
  // ****************************************************************
  localparam logic [2:0] MR0_BA            = 3'h0;
  localparam logic [2:0] MR2_BA            = 3'h2;
  localparam int         MR2_ASR_BIT       = 6;
  localparam int         MR2_SRT_BIT       = 7;
  localparam int         MR0_FAST_EXIT_BIT = 12;
  localparam int         MR0_BL_LSB        = 0;
  localparam logic [1:0] MR0_CHOP4_FIXED   = 2'h2;
  localparam int         PRE_ALL_BIT       = 10;
  localparam int         NUM_BANKS         = 8;

  // ****************************************************************
  // timing in link clock cycles
  // ****************************************************************
  localparam int         XPDLL_CK     = 10;
  localparam int         ANPD_CK      = 4;
  localparam logic [7:0] ODT_HOLD_RST = 8'(ANPD_CK + XPDLL_CK);

  // ****************************************************************
  // register map and status layout
  // ****************************************************************
  localparam int          APB_AW         = 12;
  localparam logic [11:0] STATUS_OFS     = 12'h000;
  localparam logic [11:0] CFG_OFS        = 12'h004;
  localparam int          ST_STATE_LSB   = 0;
  localparam int          ST_BANKS_LSB   = 3;
  localparam int          ST_BUF_BIT     = 11;
  localparam int          ST_DLL_BIT     = 12;
  localparam int          ST_ODT_BIT     = 13;
  localparam int          ST_AUTO_BIT    = 14;
  localparam int          ST_EXT_BIT     = 15;
  localparam int          ST_ILLEGAL_BIT = 16;
  localparam int          ST_CHOP4_BIT   = 17;
  localparam int          ST_FAST_BIT    = 18;
  localparam int          CFG_HOLD_LSB   = 0;

  // ****************************************************************
  // power state
  // ****************************************************************
  typedef enum logic [2:0] {
    PD_RUN       = 3'b001,
    PD_ACTIVE    = 3'b010,
    PD_PRECHARGE = 3'b100
  } pd_state_t;

endpackage : sdram_pd_pkg

/* File: logic/pin_if.sv */
`timescale 1ns/1ps
// synchronised pin samples with the link clock rising edge marker
interface pin_if;
  logic        ck_rise;
  logic        cke;
  logic [3:0]  cmd;
  logic [15:0] addr;
  logic [2:0]  ba;
  modport src (output ck_rise, output cke, output cmd, output addr, output ba);
  modport dst (input ck_rise, input cke, input cmd, input addr, input ba);
endinterface : pin_if

/* File: logic/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // raw pins
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic [3:0]  cmd,
  input  wire logic [15:0] addr,
  input  wire logic [2:0]  ba,
  // synchronised view
  pin_if.src               pins
);

  localparam int W = 25;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic         ck_d;
  } sync_t;

  // link clock bits reset high so that a release never looks like a rising edge
  localparam sync_t SYNC_RST = '{s1: {1'b1, 24'h00_0000}, s2: {1'b1, 24'h00_0000}, ck_d: 1'b1};

  sync_t r_reg;
  sync_t r_next;

  // ****************************************************************
  // two stage synchroniser and link clock edge finder
  // ****************************************************************
  always_comb begin
    r_next      = r_reg;
    r_next.s1   = {ck, cke, cmd, addr, ba};
    r_next.s2   = r_reg.s1;
    r_next.ck_d = r_reg.s2[W-1];
  end

  // register the whole state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg <= SYNC_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs read the second stage and its delayed clock bit ck_d, never the first stage
  assign pins.ck_rise = r_reg.s2[W-1] & ~r_reg.ck_d;
  assign pins.cke     = r_reg.s2[W-2];
  assign pins.cmd     = r_reg.s2[22:19];
  assign pins.addr    = r_reg.s2[18:3];
  assign pins.ba      = r_reg.s2[2:0];

endmodule : pin_sync

/* File: tb/mem_ctrl_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// memory controller model: link clock and command pins
// ****************************************************************
module mem_ctrl_model (
  // link pins
  output logic        ck,
  output logic        cke,
  output logic [3:0]  cmd,
  output logic [15:0] addr,
  output logic [2:0]  ba
);
  // pins idle as nop with cke high; no self refresh is ever issued
  initial begin
    cke = 1'b1;
    cmd = sdram_pd_pkg::CMD_NOP;
    addr = 16'h0000;
    ba = 3'h0;
  end
  // link clock runs free, stable through power-down
  initial begin
    ck = 1'b0;
    forever #40 ck = ~ck;
  end
  // one link cycle: pins move on the falling edge, device samples on the rise
  task automatic cyc(input logic k, input logic [3:0] c, input logic [15:0] a,
                     input logic [2:0] b);
    @(negedge ck);
    cke <= k;
    cmd <= c;
    addr <= a;
    ba <= b;
    @(posedge ck);
  endtask : cyc
  // idle cycle: address lines flipped so no stale value looks valid
  task automatic nop(input logic k);
    cyc(k, sdram_pd_pkg::CMD_NOP, ~addr, ~ba);
  endtask : nop
  // command, then nops so it has finished before any entry
  task automatic issue(input logic [3:0] c, input logic [15:0] a, input logic [2:0] b);
    cyc(1'b1, c, a, b);
    repeat (4) nop(1'b1);
  endtask : issue
  // entry with nop or deselect, then low with nops only; loop off in slow-exit precharge power-down
  task automatic enter(input logic desel);
    cyc(1'b0, desel ? 4'hf : sdram_pd_pkg::CMD_NOP, ~addr, ~ba);
    repeat (3) nop(1'b0);
  endtask : enter
endmodule : mem_ctrl_model

/* File: tb/sdram_pd_ctrl_test.sv */
`timescale 1ns/1ps
module sdram_pd_ctrl_test;
  logic        core_clk = 1'b0;
  logic        rst, ck, cke, psel, penable, pwrite, pready, pslverr;
  logic [3:0]  cmd;
  logic [15:0] addr;
  logic [2:0]  ba;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        input_buf_en, dll_on, odt_async, pd_active, pd_precharge;
  logic        sr_rate_auto, sr_range_ext, mr2_illegal, err;
  int          fail_count, tests_run, cycles;

  // ****************************************************************
  // design and controller model
  // ****************************************************************
  sdram_pd_ctrl i_sdram_pd_ctrl (.core_clk(core_clk), .rst(rst), .ck(ck), .cke(cke),
    .cmd(cmd), .addr(addr), .ba(ba), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_buf_en(input_buf_en), .dll_on(dll_on), .odt_async(odt_async),
    .pd_active(pd_active), .pd_precharge(pd_precharge), .sr_rate_auto(sr_rate_auto),
    .sr_range_ext(sr_range_ext), .mr2_illegal(mr2_illegal));
  mem_ctrl_model i_mem_ctrl_model (.ck(ck), .cke(cke), .cmd(cmd), .addr(addr), .ba(ba));

  // core clock and hang limit
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      fail_count++;
      finish_test();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic check1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check1
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check32
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // let the synchroniser pass the last link edge
  task automatic settle();
    repeat (6) @(posedge core_clk);
  endtask : settle
  // power outputs as one group
  task automatic check_pd(input logic act, input logic pre, input logic bufe, input logic dll);
    check1(pd_active, act);
    check1(pd_precharge, pre);
    check1(input_buf_en, bufe);
    check1(dll_on, dll);
  endtask : check_pd

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    check_pd(1'b0, 1'b0, 1'b1, 1'b1);
    apb(1'b0, sdram_pd_pkg::STATUS_OFS, 32'h0);
    check1(pready, 1'b1);
    check32(rd, 32'h00001801);
    apb(1'b1, sdram_pd_pkg::STATUS_OFS, 32'hffffffff);
    apb(1'b0, sdram_pd_pkg::STATUS_OFS, 32'h0);
    check32(rd, 32'h00001801);
    apb(1'b0, sdram_pd_pkg::CFG_OFS, 32'h0);
    check32(rd, 32'h0000000e);
    apb(1'b1, sdram_pd_pkg::CFG_OFS, 32'h00000003);
    apb(1'b0, sdram_pd_pkg::CFG_OFS, 32'h0);
    check32(rd, 32'h00000003);
    apb(1'b0, 12'h008, 32'h0);
    check1(err, 1'b1);
    check32(rd, 32'h0);
  endtask : t_regs
  task automatic t_mode();
    for (int i = 3; i >= 0; i--) begin
      i_mem_ctrl_model.issue(sdram_pd_pkg::CMD_MRS, 16'(i << 6), sdram_pd_pkg::MR2_BA);
      check1(sr_rate_auto, i[0]);
      check1(sr_range_ext, i == 2);
      check1(mr2_illegal, i == 3);
    end
  endtask : t_mode
  task automatic t_refuse();
    i_mem_ctrl_model.cyc(1'b0, sdram_pd_pkg::CMD_ACT, 16'h0000, 3'h0);
    settle();
    check_pd(1'b0, 1'b0, 1'b1, 1'b1);
    i_mem_ctrl_model.nop(1'b0);
    settle();
    check1(input_buf_en, 1'b1);
    repeat (2) i_mem_ctrl_model.nop(1'b1);
  endtask : t_refuse
  task automatic t_slow();
    i_mem_ctrl_model.issue(sdram_pd_pkg::CMD_MRS, 16'h0000, sdram_pd_pkg::MR0_BA);
    i_mem_ctrl_model.enter(1'b0);
    check_pd(1'b0, 1'b1, 1'b0, 1'b0);
    check1(odt_async, 1'b1);
    i_mem_ctrl_model.cyc(1'b0, sdram_pd_pkg::CMD_ACT, 16'h0000, 3'h1);
    apb(1'b0, sdram_pd_pkg::STATUS_OFS, 32'h0);
    check32(rd, 32'h00002004);
    i_mem_ctrl_model.nop(1'b1);
    settle();
    check_pd(1'b0, 1'b0, 1'b1, 1'b1);
    i_mem_ctrl_model.nop(1'b1);
    i_mem_ctrl_model.nop(1'b1);
    settle();
    check1(odt_async, 1'b1);
    repeat (2) i_mem_ctrl_model.nop(1'b1);
    settle();
    check1(odt_async, 1'b0);
  endtask : t_slow
  task automatic t_fast();
    i_mem_ctrl_model.issue(sdram_pd_pkg::CMD_MRS, 16'h1000, sdram_pd_pkg::MR0_BA);
    i_mem_ctrl_model.enter(1'b1);
    check_pd(1'b0, 1'b1, 1'b0, 1'b1);
    check1(odt_async, 1'b0);
    repeat (2) i_mem_ctrl_model.nop(1'b1);
    check_pd(1'b0, 1'b0, 1'b1, 1'b1);
  endtask : t_fast
  task automatic t_active();
    i_mem_ctrl_model.cyc(1'b1, sdram_pd_pkg::CMD_ACT, 16'h0000, 3'h3);
    i_mem_ctrl_model.nop(1'b1);
    i_mem_ctrl_model.enter(1'b0);
    check_pd(1'b1, 1'b0, 1'b0, 1'b1);
    apb(1'b0, sdram_pd_pkg::STATUS_OFS, 32'h0);
    check32((rd >> 3) & 32'hff, 32'h00000008);
    repeat (2) i_mem_ctrl_model.nop(1'b1);
    i_mem_ctrl_model.issue(sdram_pd_pkg::CMD_PRE, 16'h0400, 3'h0);
    i_mem_ctrl_model.enter(1'b0);
    check_pd(1'b0, 1'b1, 1'b0, 1'b1);
    repeat (2) i_mem_ctrl_model.nop(1'b1);
  endtask : t_active
  // reset in the middle of power-down brings back the run state and defaults
  task automatic t_reset();
    i_mem_ctrl_model.enter(1'b0);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    check_pd(1'b0, 1'b0, 1'b1, 1'b1);
    check1(odt_async, 1'b0);
    apb(1'b0, sdram_pd_pkg::CFG_OFS, 32'h0);
    check32(rd, 32'h0000000e);
    apb(1'b0, sdram_pd_pkg::STATUS_OFS, 32'h0);
    check32(rd, 32'h00001801);
    repeat (2) i_mem_ctrl_model.nop(1'b1);
    check_pd(1'b0, 1'b0, 1'b1, 1'b1);
  endtask : t_reset

  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fail_count, tests_run, cycles} = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_mode();
    t_refuse();
    t_slow();
    t_fast();
    t_active();
    t_reset();
    finish_test();
  end
endmodule : sdram_pd_ctrl_test
